// >>> rtl/spcr_pkg.sv
package spcr_pkg;
  // ==========================================================
  // Register map (printed offsets are indices, byte = 4 x idx)
  localparam logic [7:0] SMC_IDX = 8'hFF;  // supply_monitor_control
  localparam logic [7:0] RSR_IDX = 8'hEF;  // reset_source_register

  // ==========================================================
  // Field positions
  localparam int SMC_ON_BIT   = 7;  // supply_monitor_on
  localparam int SMC_STAT_BIT = 6;  // supply_level_status
  localparam int SMC_LVL_BIT  = 5;  // threshold_level_select
  localparam int RSR_PIN_BIT  = 0;  // pin_reset_flag
  localparam int RSR_POR_BIT  = 1;  // power_on_flag / monitor select
  localparam int RSR_LOSS_BIT = 2;  // clock_loss_flag / detector on
  localparam int RSR_FERR_BIT = 6;  // flash error flag

  // ==========================================================
  // Reset values
  localparam logic MON_ON_RST  = 1'b1;  // Monitor on after power-on
  localparam logic LVL_RST     = 1'b0;  // lower_threshold
  localparam logic MON_SEL_RST = 1'b1;  // Monitor selected after POR
  localparam logic LOSS_EN_RST = 1'b0;  // Detector off after POR
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LOSS_TIME_US  = 100;  // Clock-loss timeout
  localparam int LOSS_CYC = (LOSS_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int POR_DELAY_US  = 100;  // Power-on release delay
  localparam int POR_DELAY_CYC = (POR_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int HOLD_MIN_CYC  = 16;   // Least reset pulse
  localparam int PIN_GUARD_W   = 3;    // Own-drive echo guard

  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_POR, ST_HOLD, ST_RUN} spcr_state_t;
  typedef enum logic [2:0] {
    CA_NONE, CA_MON, CA_PIN, CA_LOSS, CA_FERR
  } spcr_cause_t;
endpackage

// >>> rtl/spcr_loss_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the clock-loss detector's control and result
interface spcr_loss_if;
  logic watched;  // Raw watched clock, not yet synchronised
  logic enable;   // Detector enabled by software
  logic lost;     // Timeout level, held while clock is missing
  modport det  (input watched, input enable, output lost);
  modport ctrl (output watched, output enable, input lost);
endinterface
`default_nettype wire

// >>> rtl/spcr_clock_loss.sv
`timescale 1ns/1ps
`default_nettype none
module spcr_clock_loss #(
  parameter int TimeoutCycles = spcr_pkg::LOSS_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Detector link
  spcr_loss_if.det  lp
);
  localparam int CW = $clog2(TimeoutCycles + 1);
  localparam logic [CW-1:0] LAST = CW'(TimeoutCycles - 1);

  // ==========================================================
  // Elaboration check
  if (TimeoutCycles < 2) begin : g_chk
    $error("TimeoutCycles must be at least 2");
  end

  logic          s1_ff;   // First sync stage, read only by s2
  logic          s2_ff;   // Second sync stage
  logic          s3_ff;   // Previous value for edge detect
  logic [CW-1:0] cnt_ff;  // Cycles since last edge
  logic          lost_ff; // Timeout level

  // ==========================================================
  // Synchroniser for the watched clock
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= lp.watched;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // ==========================================================
  // One-shot: any edge retriggers, a steady level times out
  always_ff @(posedge clk) begin
    if (rst || !lp.enable || (s2_ff ^ s3_ff)) begin
      cnt_ff  <= '0;  // R16
      lost_ff <= 1'b0;
    end else if (cnt_ff == LAST) begin
      lost_ff <= 1'b1;  // R20
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign lp.lost = lost_ff;
endmodule  // spcr_clock_loss
`default_nettype wire

// >>> rtl/supply_pin_clockloss_reset.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Low supply drives pin, holds core reset
// R2: Reset never touches data memory contents
// R3: Only power-on reset re-enables supply monitor
// R4: Flash write without high, selected monitor resets
// R5: Software enables monitor before selecting it
// R6: Writing power-on flag one selects monitor
// R7: No power-on delay after monitor reset
// R8: High threshold may hold reset until POR
// R9: Power-on reset returns threshold to low
// R10: Software keeps threshold low except programming
// R11: Enable bit seven; resets need selection too
// R12: Bit six reads live synchronised monitor output
// R13: Bit five selects threshold, resets low
// R14: Bits four to zero read zero
// R15: Low pin resets; pin flag set after
// R16: Clock-loss one-shot retriggered by watched clock
// R17: Clock-loss flag set only after its reset
// R18: Clock-loss flag write enables or disables detector
// R19: Clock-loss reset leaves the pin alone
// R20: Clock-loss timeout about one hundred microseconds
// R21: Power-on flag set by POR, cleared otherwise; a monitor reset here sets it too
// R22: Monitor and pin inputs synchronised first
// R23: Sources merge; causing flag captured at release
module supply_pin_clockloss_reset #(
  parameter int PorDelayCycles = spcr_pkg::POR_DELAY_CYC,
  parameter int LossCycles     = spcr_pkg::LOSS_CYC
) (
  // Clock and reset (rst is the power-on reset)
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Supply monitor analog side
  input  wire logic        supplyAbove,
  output logic             supplyMonitorOn,
  output logic             thresholdLevelSelect,
  // Open-drain reset pin
  input  wire logic        resetPinIn,
  output logic             resetPinOut,
  output logic             resetPinOeN,
  // Watched system clock and flash requests
  input  wire logic        watchedClk,
  input  wire logic        flashWriteReq,
  // System reset to the core
  output logic             systemReset
);
  localparam logic [15:0] POR_LAST  = 16'(PorDelayCycles - 1);
  localparam logic [15:0] HOLD_LAST = 16'(spcr_pkg::HOLD_MIN_CYC - 1);

  // ==========================================================
  // Elaboration check
  if (PorDelayCycles < 1 || PorDelayCycles > 65535) begin : g_chk
    $error("PorDelayCycles must lie in 1..65535");
  end

  // ==========================================================
  // Declarations
  logic               supS1_ff;     // Monitor sync stage 1
  logic               supS2_ff;     // Monitor sync stage 2
  logic               pinS1_ff;     // Pin sync stage 1
  logic               pinS2_ff;     // Pin sync stage 2
  logic               monOn_ff;     // supply_monitor_on
  logic               lvl_ff;       // threshold_level_select
  logic               monSel_ff;    // Monitor chosen as source
  logic               lossEn_ff;    // Detector enable
  logic [7:0]         flags_ff;     // Reset cause flags
  spcr_pkg::spcr_state_t state_ff;  // Reset sequencer state
  spcr_pkg::spcr_cause_t cause_ff;  // Cause of current reset
  logic [15:0]        cnt_ff;       // Delay and hold counter
  logic               sysRst_ff;    // Core reset
  logic               pinDrvN_ff;   // Low while pulling pin
  logic [spcr_pkg::PIN_GUARD_W-1:0] drvHist_ff; // Drive echo
  logic               wrSmc_ff;     // Pending write, control
  logic               wrRsr_ff;     // Pending write, sources
  logic [31:0]        hrdata_ff;    // Read data
  logic               hready_ff;    // Always ready after reset
  logic               monTrip;      // Monitor reset request
  logic               pinLow;       // Pin reset request
  logic               ferr;         // Flash error request
  logic               anyLevel;     // Any level source active
  logic               apSel;        // Address phase taken
  logic               addrSmc;      // Address hits control
  logic               addrRsr;      // Address hits sources
  logic [7:0]         smcRead;      // Control read value

  spcr_loss_if lossIf ();

  // ==========================================================
  // Clock-loss detector
  assign lossIf.watched = watchedClk;
  assign lossIf.enable  = lossEn_ff;

  spcr_clock_loss #(
    .TimeoutCycles (LossCycles)
  ) u_loss (
    .clk (clk),
    .rst (rst),
    .lp  (lossIf)
  );

  // ==========================================================
  // Input synchronisers for analog and pin levels
  always_ff @(posedge clk) begin
    if (rst) begin
      supS1_ff <= 1'b0;
      supS2_ff <= 1'b0;
      pinS1_ff <= 1'b1;
      pinS2_ff <= 1'b1;
    end else begin
      supS1_ff <= supplyAbove;  // R22
      supS2_ff <= supS1_ff;
      pinS1_ff <= resetPinIn;   // R22
      pinS2_ff <= pinS1_ff;
    end
  end

  // ==========================================================
  // Reset source requests
  // Monitor resets only when on and also selected
  assign monTrip = monOn_ff && monSel_ff && !supS2_ff;  // R11
  // Our own pull shows up two cycles late, so the pin is
  // ignored while driving and for a few cycles after
  assign pinLow  = !pinS2_ff && pinDrvN_ff && (drvHist_ff == '0);
  // Flash write needs monitor on, high and selected
  assign ferr    = flashWriteReq &&
                   !(monOn_ff && monSel_ff && lvl_ff);  // R4
  assign anyLevel = monTrip || pinLow || lossIf.lost;

  // ==========================================================
  // Reset sequencer: power-up, hold and release
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff   <= spcr_pkg::ST_POR;
      cause_ff   <= spcr_pkg::CA_NONE;
      cnt_ff     <= '0;
      sysRst_ff  <= 1'b1;
      pinDrvN_ff <= 1'b0;  // Power-up pulls the pin low
    end else begin
      unique case (state_ff)
        spcr_pkg::ST_POR: begin
          // Wait for supply, then the power-on delay
          if (!supS2_ff) begin
            cnt_ff <= '0;
          end else if (cnt_ff == POR_LAST) begin
            state_ff   <= spcr_pkg::ST_RUN;
            sysRst_ff  <= 1'b0;
            pinDrvN_ff <= 1'b1;
            cnt_ff     <= '0;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        spcr_pkg::ST_RUN: begin
          // Merge sources, fixed priority for the cause
          if (monTrip) begin
            cause_ff   <= spcr_pkg::CA_MON;  // R23
            pinDrvN_ff <= 1'b0;              // R1
            state_ff   <= spcr_pkg::ST_HOLD;
            sysRst_ff  <= 1'b1;              // R1
          end else if (pinLow) begin
            cause_ff  <= spcr_pkg::CA_PIN;   // R15
            state_ff  <= spcr_pkg::ST_HOLD;
            sysRst_ff <= 1'b1;
          end else if (lossIf.lost) begin
            cause_ff  <= spcr_pkg::CA_LOSS;  // R19
            state_ff  <= spcr_pkg::ST_HOLD;
            sysRst_ff <= 1'b1;
          end else if (ferr) begin
            cause_ff  <= spcr_pkg::CA_FERR;  // R4
            state_ff  <= spcr_pkg::ST_HOLD;
            sysRst_ff <= 1'b1;
          end
          cnt_ff <= '0;
        end
        spcr_pkg::ST_HOLD: begin
          // A level source keeps reset; with the threshold
          // high and a low supply this lasts until power-on
          if (anyLevel) begin
            cnt_ff <= '0;  // R8
            if (monTrip) begin
              pinDrvN_ff <= 1'b0;  // R1
            end
          end else if (cnt_ff == HOLD_LAST) begin
            // Straight back to run, no power-on delay
            state_ff   <= spcr_pkg::ST_RUN;  // R7
            sysRst_ff  <= 1'b0;              // R1
            pinDrvN_ff <= 1'b1;
            cnt_ff     <= '0;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Pin drive history, masks the echo of our own pull
  always_ff @(posedge clk) begin
    if (rst) begin
      drvHist_ff <= '1;
    end else begin
      drvHist_ff <= {drvHist_ff[spcr_pkg::PIN_GUARD_W-2:0],
                     !pinDrvN_ff};
    end
  end

  // ==========================================================
  // Reset cause flags, written on the release edge only
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_ff <= spcr_pkg::FLAGS_RST;
    end else if (state_ff == spcr_pkg::ST_POR && supS2_ff &&
                 cnt_ff == POR_LAST) begin
      flags_ff <= '0;
      flags_ff[spcr_pkg::RSR_POR_BIT] <= 1'b1;  // R21
    end else if (state_ff == spcr_pkg::ST_HOLD && !anyLevel &&
                 cnt_ff == HOLD_LAST) begin
      // Every other cause except the monitor clears the power-on flag
      flags_ff <= '0;  // R21
      unique case (cause_ff)
        spcr_pkg::CA_MON:
          flags_ff[spcr_pkg::RSR_POR_BIT] <= 1'b1;   // R21
        spcr_pkg::CA_PIN:
          flags_ff[spcr_pkg::RSR_PIN_BIT] <= 1'b1;   // R15
        spcr_pkg::CA_LOSS:
          flags_ff[spcr_pkg::RSR_LOSS_BIT] <= 1'b1;  // R17
        spcr_pkg::CA_FERR:
          flags_ff[spcr_pkg::RSR_FERR_BIT] <= 1'b1;
        default: begin
          flags_ff <= '0;  // Cause code not set: no flag
        end
      endcase
    end
  end

  // ==========================================================
  // Monitor control bits; only power-on reset resets them,
  // the system reset this block makes leaves them alone
  always_ff @(posedge clk) begin
    if (rst) begin
      monOn_ff  <= spcr_pkg::MON_ON_RST;   // R3
      lvl_ff    <= spcr_pkg::LVL_RST;      // R9
      monSel_ff <= spcr_pkg::MON_SEL_RST;
    end else begin
      if (wrSmc_ff) begin
        monOn_ff <= hwdata[spcr_pkg::SMC_ON_BIT];   // R11
        lvl_ff   <= hwdata[spcr_pkg::SMC_LVL_BIT];  // R13
      end
      if (wrRsr_ff) begin
        // Selecting an unsettled monitor may reset at once
        monSel_ff <= hwdata[spcr_pkg::RSR_POR_BIT];  // R6
      end
    end
  end

  // ==========================================================
  // Clock-loss detector enable
  always_ff @(posedge clk) begin
    if (rst) begin
      lossEn_ff <= spcr_pkg::LOSS_EN_RST;
    end else if (wrRsr_ff) begin
      lossEn_ff <= hwdata[spcr_pkg::RSR_LOSS_BIT];  // R18
    end
  end

  // ==========================================================
  // AHB-Lite decode; zero wait states, always OKAY
  assign apSel   = hsel && hready && htrans[1];
  assign addrSmc = (haddr[31:10] == '0) &&
                   (haddr[9:2] == spcr_pkg::SMC_IDX);
  assign addrRsr = (haddr[31:10] == '0) &&
                   (haddr[9:2] == spcr_pkg::RSR_IDX);

  // Control register read image, low bits always zero
  always_comb begin
    smcRead = 8'h00;  // R14
    smcRead[spcr_pkg::SMC_ON_BIT]   = monOn_ff;
    smcRead[spcr_pkg::SMC_STAT_BIT] = supS2_ff;  // R12
    smcRead[spcr_pkg::SMC_LVL_BIT]  = lvl_ff;
  end

  // ==========================================================
  // Address phase capture, write data taken one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      wrSmc_ff  <= 1'b0;
      wrRsr_ff  <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
      hready_ff <= 1'b1;
    end else begin
      wrSmc_ff  <= apSel && hwrite && addrSmc;
      wrRsr_ff  <= apSel && hwrite && addrRsr;
      hready_ff <= 1'b1;
      if (apSel && !hwrite && addrSmc) begin
        hrdata_ff <= {24'h00_0000, smcRead};
      end else if (apSel && !hwrite && addrRsr) begin
        hrdata_ff <= {24'h00_0000, flags_ff};  // R23
      end else begin
        // Unmapped or idle: reads as zero
        hrdata_ff <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign hreadyout            = hready_ff;
  assign hresp                = 1'b0 & hready_ff;
  assign hrdata               = hrdata_ff;
  assign supplyMonitorOn      = monOn_ff;
  assign thresholdLevelSelect = lvl_ff;
  assign resetPinOut          = 1'b0 & pinDrvN_ff;
  assign resetPinOeN          = pinDrvN_ff;
  assign systemReset          = sysRst_ff;

  // Word transfers only; hsize is accepted and ignored
  logic unusedSize;
  assign unusedSize = ^hsize;
endmodule  // supply_pin_clockloss_reset
`default_nettype wire

// >>> verif/spcr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// External reset circuitry on the open-drain pin
module spcr_pin_model (
  // Device side of the pin
  input  wire logic resetPinOut,
  input  wire logic resetPinOeN,
  // Bench command: hold the pin low from outside
  input  wire logic pressLow,
  // Resolved wire level
  output logic      resetPinIn
);
  // Pull-up: a released wire reads high, never its last value
  assign resetPinIn = ((!resetPinOeN && !resetPinOut) || pressLow)
                      ? 1'b0 : 1'b1;
endmodule // spcr_pin_model
`default_nettype wire

// >>> verif/spcr_reset_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port-level checker for the reset block
module spcr_reset_monitor (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  input  wire logic [31:0] hrdata,
  // Supply, pin, flash and core reset
  input  wire logic        supplyAbove,
  input  wire logic        supplyMonitorOn,
  input  wire logic        thresholdLevelSelect,
  input  wire logic        resetPinIn,
  input  wire logic        resetPinOeN,
  input  wire logic        flashWriteReq,
  input  wire logic        systemReset
);
  localparam logic [31:0] CTL = {22'h0, spcr_pkg::SMC_IDX, 2'h0};
  logic takeRd;    // Read address phase accepted
  logic rdAny_ff;  // Data phase of any read
  logic rdCtl_ff;  // Data phase of a control read
  assign takeRd = hsel && hready && htrans[1] && !hwrite;
  // ==========================================
  // Track read data phases
  always_ff @(posedge clk) begin
    if (rst) begin
      rdAny_ff <= 1'b0;
      rdCtl_ff <= 1'b0;
    end else begin
      rdAny_ff <= takeRd;
      rdCtl_ff <= takeRd && (haddr == CTL);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Assertions
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  chk_read_idle: assert property (!rdAny_ff |-> hrdata == 32'h0)
    else $error("read data outside a data phase");
  chk_ctl_zero: assert property (
    rdCtl_ff |-> hrdata[4:0] == 5'h0 && hrdata[31:8] == 24'h0)
    else $error("control read shows unused bits");
  chk_pin_core: assert property (!resetPinOeN |-> systemReset)
    else $error("pin driven while core runs");
  chk_por_defaults: assert property (
    @(posedge clk) disable iff (1'b0)
    rst |=> supplyMonitorOn && !thresholdLevelSelect)
    else $error("power-on defaults wrong");
  chk_pin_reset: assert property (
    !systemReset && !resetPinIn && resetPinOeN && $past(resetPinOeN, 4)
    |-> ##[1:4] systemReset)
    else $error("low pin gave no reset");
  chk_loss_pin: assert property (
    supplyAbove[*6] ##0 (systemReset && $past(resetPinOeN))
    |-> resetPinOeN)
    else $error("non-monitor reset drove the pin");
  chk_flash_err: assert property (
    flashWriteReq && !thresholdLevelSelect && !systemReset
    |-> ##[1:2] systemReset)
    else $error("flash at low threshold gave no reset");
  chk_min_hold: assert property ($rose(systemReset) |=> systemReset[*8])
    else $error("core reset pulse too short");
  // Main scenarios seen
  cover property ($rose(systemReset) && resetPinOeN);
  cover property (rdCtl_ff);
  cover property (flashWriteReq && thresholdLevelSelect);
endmodule // spcr_reset_monitor
bind supply_pin_clockloss_reset spcr_reset_monitor u_mon (
  .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .supplyAbove, .supplyMonitorOn,
  .thresholdLevelSelect, .resetPinIn, .resetPinOeN, .flashWriteReq,
  .systemReset);
`default_nettype wire

// >>> verif/supply_pin_clockloss_reset_tb.sv
`timescale 1ns/1ps
`default_nettype none
module supply_pin_clockloss_reset_tb;
  localparam logic [31:0] CTL = {22'h0, spcr_pkg::SMC_IDX, 2'h0};
  localparam logic [31:0] SRC = {22'h0, spcr_pkg::RSR_IDX, 2'h0};
  // Bench-driven inputs
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        supplyAbove = 1'b1, watchedClk = 1'b0;
  logic        flashWriteReq = 1'b0, pressLow = 1'b0, wStop = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0;
  // Design outputs and resolved wires
  logic        hready, hreadyout, hresp, supplyMonitorOn;
  logic        thresholdLevelSelect, resetPinIn, resetPinOut;
  logic        resetPinOeN, systemReset;
  logic [31:0] hrdata;
  int          errTotal = 0, samplesChecked = 0, cycles = 0;
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  always #50 clk = ~clk;
  // Watched clock runs free unless a scenario stops it
  always @(posedge clk) if (!wStop) watchedClk <= ~watchedClk;
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      results();
    end
  end
  supply_pin_clockloss_reset #(.PorDelayCycles(10), .LossCycles(20)) dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .supplyAbove(supplyAbove), .supplyMonitorOn(supplyMonitorOn),
    .thresholdLevelSelect(thresholdLevelSelect), .resetPinIn(resetPinIn),
    .resetPinOut(resetPinOut), .resetPinOeN(resetPinOeN),
    .watchedClk(watchedClk), .flashWriteReq(flashWriteReq),
    .systemReset(systemReset));
  spcr_pin_model u_pin (.resetPinOut(resetPinOut),
    .resetPinOeN(resetPinOeN), .pressLow(pressLow),
    .resetPinIn(resetPinIn));
  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One single transfer; waits for ready in both phases
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // Wait for core release, bounded; returns cycles waited
  task automatic rel(output int n);
    for (n = 0; n < 400 && systemReset !== 1'b0; n++) @(posedge clk);
    check(systemReset, 32'h0);
  endtask
  task automatic flash();
    flashWriteReq <= 1'b1;
    @(posedge clk);
    flashWriteReq <= 1'b0;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_por();
    int n;
    rel(n);
    rdchk(CTL, 32'hC0);
    rdchk(SRC, 32'h02);
    rdchk(32'h0, 32'h0);
    bus(1'b1, CTL, 32'hFF);
    rdchk(CTL, 32'hE0);
    bus(1'b1, CTL, 32'h40);
    supplyAbove <= 1'b0;
    cyc(6);
    check(systemReset, 32'h0);
    rdchk(CTL, 32'h00);
    supplyAbove <= 1'b1;
    cyc(4);
  endtask
  task automatic t_pin();
    int n;
    pressLow <= 1'b1;
    cyc(5);
    check(systemReset, 32'h1);
    pressLow <= 1'b0;
    rel(n);
    rdchk(SRC, 32'h01);
    rdchk(CTL, 32'h40);
  endtask
  task automatic t_flash();
    int n;
    bus(1'b1, CTL, 32'h80);
    bus(1'b1, SRC, 32'h02);
    flash();
    cyc(2);
    check(systemReset, 32'h1);
    rel(n);
    rdchk(SRC, 32'h40);
    bus(1'b1, CTL, 32'hA0);
    flash();
    cyc(4);
    check(systemReset, 32'h0);
    bus(1'b1, CTL, 32'h80);
  endtask
  task automatic t_trip();
    int n;
    supplyAbove <= 1'b0;
    cyc(5);
    check(systemReset, 32'h1);
    check(resetPinIn, 32'h0);
    supplyAbove <= 1'b1;
    rel(n);
    check(n < 24, 32'h1);
    rdchk(SRC, 32'h02);
  endtask
  task automatic t_loss();
    int n;
    bus(1'b1, SRC, 32'h02);
    wStop <= 1'b1;
    cyc(40);
    check(systemReset, 32'h0);
    wStop <= 1'b0;
    bus(1'b1, SRC, 32'h06);
    wStop <= 1'b1;
    cyc(10);
    check(systemReset, 32'h0);
    for (n = 0; n < 30 && systemReset !== 1'b1; n++) @(posedge clk);
    check(systemReset, 32'h1);
    check(resetPinOeN, 32'h1);
    wStop <= 1'b0;
    rel(n);
    rdchk(SRC, 32'h04);
  endtask
  task automatic t_hi();
    int n;
    bus(1'b1, CTL, 32'hA0);
    supplyAbove <= 1'b0;
    // Uncalibrated regulator stays under the high threshold
    cyc(40);
    check(systemReset, 32'h1);
    check(resetPinOeN, 32'h0);
    // Power-on lowers the threshold, so the comparator clears
    rst <= 1'b1;
    supplyAbove <= 1'b1;
    cyc(16);
    rst <= 1'b0;
    rel(n);
    rdchk(CTL, 32'hC0);
    rdchk(SRC, 32'h02);
  endtask
  // ==========================================
  // Verdict and end of run
  task automatic results();
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    cyc(16);
    rst <= 1'b0;
    t_por();
    t_pin();
    t_flash();
    t_trip();
    t_loss();
    t_hi();
    results();
  end
endmodule // supply_pin_clockloss_reset_tb
`default_nettype wire
